//--- pkg/op_pkg.sv
// Opcodes, field positions and constants for the move/return decoder
`default_nettype none
package op_pkg;
    localparam int          INSN_W        = 14;
    localparam int          PC_W          = 9;
    localparam int          FADDR_W       = 7;
    localparam int          DEST_BIT      = 7;
    localparam int          GIE_BIT       = 7;
    localparam logic [13:0] OPC_NOP       = 14'h0000;
    localparam logic [13:0] OPC_RETFIRQ   = 14'h0009;
    localparam logic [6:0]  PAT_STORE_ACC = 7'h01;
    localparam logic [5:0]  PAT_MOVE_FILE = 6'h08;
    localparam logic [3:0]  PAT_LOAD_LIT  = 4'h3;
    localparam logic [7:0]  W_RESET       = 8'h00;
    localparam logic [7:0]  IRQCTL_RESET  = 8'h00;
    localparam logic [8:0]  PC_RESET      = 9'h000;
    localparam int          STACK_DEPTH   = 8;
endpackage
`default_nettype wire

//--- pkg/stack_if.sv
// Push/pop carrier between the core and its return stack
`default_nettype none
interface stack_if #(parameter int W = 9);
    logic         push;
    logic         pop;
    logic [W-1:0] push_data;
    logic [W-1:0] top;
    modport core  (output push, output pop, output push_data, input top);
    modport stack (input push, input pop, input push_data, output top);
endinterface
`default_nettype wire

//--- core/ret_stack.sv
// Circular hardware return stack with registered top
`default_nettype none
module ret_stack #(
    parameter int W     = 9,
    parameter int DEPTH = 8
) (
    input  wire logic clk,
    input  wire logic rst_n,
    stack_if.stack    port
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] ptr;
    logic [AW-1:0] next_ptr;
    logic [AW-1:0] read_ptr;

    // Overflow wraps, matching a fixed-depth circular stack
    assign next_ptr = port.push ? ptr + 1'b1 : ptr - 1'b1;
    assign read_ptr = port.push ? next_ptr : ptr - 1'b1;

    always_ff @(posedge clk) begin
        if (port.push) begin
            mem[next_ptr] <= port.push_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= '0;
        end else if (port.push || port.pop) begin
            ptr <= next_ptr;
        end
    end

    // Top after the operation; on a push the new value is forwarded
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port.top <= '0;
        end else if (port.push) begin
            port.top <= port.push_data;
        end else if (port.pop) begin
            port.top <= mem[read_ptr];
        end
    end
endmodule
`default_nettype wire

//--- core/move_ret_decoder.sv
// Executes move, store, literal load, no-op and interrupt return
`default_nettype none
// Behaviour
// RULE1: Move-file copies register f to W when d is 0 or back to f when d is 1, one cycle.
// RULE2: Move-file sets the zero flag from the moved value for both destinations.
// RULE3: Store-accumulator writes W into register f in one cycle, flags untouched.
// RULE4: Load-literal puts its 8-bit literal into W in one cycle, flags untouched.
// RULE5: Assemblers fill unused literal-opcode bits with zeros.
// RULE6: Interrupt return pops the stack and loads the popped top into the PC.
// RULE7: Interrupt return sets the global interrupt enable, control bit 7.
// RULE8: Interrupt return takes two cycles; the second executes nothing.
// RULE9: No-op takes one cycle and changes nothing but the PC.
module move_ret_decoder
    import op_pkg::*;
#(
    parameter int PC_WIDTH = PC_W,
    parameter int DEPTH    = STACK_DEPTH
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 insn_valid,
    input  wire logic [INSN_W-1:0]    insn,
    input  wire logic [7:0]           file_rdata,
    input  wire logic                 call_push,
    input  wire logic [PC_WIDTH-1:0]  call_addr,
    output logic [PC_WIDTH-1:0]       pc,
    output logic [7:0]                w_reg,
    output logic                      zero_flag,
    output logic [7:0]                irq_control_reg,
    output logic                      file_we,
    output logic [FADDR_W-1:0]        file_addr,
    output logic [7:0]                file_wdata,
    output logic                      flush,
    output logic                      insn_ack
);
    logic rst_meta;
    logic rst_n;
    logic ret_busy;
    logic [PC_WIDTH-1:0] ret_target;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    stack_if #(.W(PC_WIDTH)) stk ();
    ret_stack #(.W(PC_WIDTH), .DEPTH(DEPTH)) u_stack (
        .clk   (clk),
        .rst_n (rst_n),
        .port  (stk)
    );

    wire       go       = insn_valid && !ret_busy;
    wire       is_move  = insn[13:8] == PAT_MOVE_FILE;
    wire       is_store = insn[13:7] == PAT_STORE_ACC;
    wire       is_lit   = insn[13:10] == PAT_LOAD_LIT;
    wire       is_ret   = insn == OPC_RETFIRQ;
    wire       dest_f   = insn[DEST_BIT];
    wire [6:0] faddr    = insn[FADDR_W-1:0];
    wire       do_move  = go && is_move;
    wire       do_store = go && is_store;
    wire       do_lit   = go && is_lit;
    wire       do_ret   = go && is_ret;
    // Pop in the first cycle; the stack top register then already shows
    // the entry below, so the return address is latched beforehand
    assign stk.pop       = do_ret;
    assign stk.push      = call_push && !do_ret;
    assign stk.push_data = call_addr;

    // Second cycle of the return: PC reload, slot executes nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ret_busy <= 1'b0;
        end else begin
            ret_busy <= do_ret; // RULE8
        end
    end

    // Taken before the pop moves the stack past it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ret_target <= '0;
        end else if (do_ret) begin
            ret_target <= stk.top; // RULE6
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc <= PC_RESET;
        end else if (ret_busy) begin
            pc <= ret_target; // RULE6
        end else if (go) begin
            pc <= pc + 1'b1; // RULE9
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_reg <= W_RESET;
        end else if (do_move && !dest_f) begin
            w_reg <= file_rdata; // RULE1
        end else if (do_lit) begin
            w_reg <= insn[7:0]; // RULE4
        end
    end

    // Only move-file touches flags; store and literal leave them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_flag <= 1'b0;
        end else if (do_move) begin
            zero_flag <= file_rdata == 8'h00; // RULE2
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_control_reg <= IRQCTL_RESET;
        end else if (do_ret) begin
            irq_control_reg[GIE_BIT] <= 1'b1; // RULE7
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            file_we    <= 1'b0;
            file_addr  <= '0;
            file_wdata <= 8'h00;
            flush      <= 1'b0;
            insn_ack   <= 1'b0;
        end else begin
            file_we    <= do_store || (do_move && dest_f); // RULE3
            file_addr  <= faddr;
            file_wdata <= do_store ? w_reg : file_rdata; // RULE1
            flush      <= do_ret;
            insn_ack   <= go;
        end
    end

    // Dead slot: busy, nothing taken, fetched word flushed
    sequence s_ret_dead;
        ret_busy && !go && flush;
    endsequence

    // Slot after the dead one: no acknowledge, flush over
    sequence s_ret_done;
        !insn_ack && !flush;
    endsequence

    property p_ret_two_cycles;
        @(posedge clk) disable iff (!rst_n)
        do_ret |=> s_ret_dead ##1 s_ret_done;
    endproperty
    a_ret_two_cycles: assert property (p_ret_two_cycles) // RULE8
        else $error("return not two cycles");

    property p_ret_quiet;
        @(posedge clk) disable iff (!rst_n)
        ret_busy |=> $stable(w_reg) && $stable(zero_flag) && !file_we;
    endproperty
    a_ret_quiet: assert property (p_ret_quiet) // RULE8
        else $error("dead return slot executed something");

    property p_ret_gie;
        @(posedge clk) disable iff (!rst_n)
        do_ret |=> irq_control_reg[GIE_BIT];
    endproperty
    a_ret_gie: assert property (p_ret_gie) // RULE7
        else $error("global enable not set by return");

    property p_ret_pc;
        @(posedge clk) disable iff (!rst_n)
        do_ret |=> ##1 pc == $past(stk.top, 2);
    endproperty
    a_ret_pc: assert property (p_ret_pc) // RULE6
        else $error("pc not reloaded from stack top");

    property p_move_w;
        @(posedge clk) disable iff (!rst_n)
        do_move && !dest_f |=> w_reg == $past(file_rdata);
    endproperty
    a_move_w: assert property (p_move_w) // RULE1
        else $error("move to W wrong");

    property p_move_f;
        @(posedge clk) disable iff (!rst_n)
        do_move && dest_f |=> file_we && file_addr == $past(faddr)
            && file_wdata == $past(file_rdata);
    endproperty
    a_move_f: assert property (p_move_f) // RULE1
        else $error("move back to register wrong");

    property p_move_z;
        @(posedge clk) disable iff (!rst_n)
        do_move |=> zero_flag == ($past(file_rdata) == 8'h00);
    endproperty
    a_move_z: assert property (p_move_z) // RULE2
        else $error("zero flag wrong after move");

    property p_store;
        @(posedge clk) disable iff (!rst_n)
        do_store |=> file_we && file_wdata == $past(w_reg)
            && $stable(zero_flag);
    endproperty
    a_store: assert property (p_store) // RULE3
        else $error("store wrong");

    property p_lit;
        @(posedge clk) disable iff (!rst_n)
        do_lit |=> w_reg == $past(insn[7:0]) && $stable(zero_flag);
    endproperty
    a_lit: assert property (p_lit) // RULE4
        else $error("literal load wrong");

    property p_nop;
        @(posedge clk) disable iff (!rst_n)
        go && insn == OPC_NOP |=> !file_we && $stable(w_reg)
            && $stable(zero_flag) && pc == $past(pc) + 1'b1;
    endproperty
    a_nop: assert property (p_nop) // RULE9
        else $error("no-op changed state");
endmodule
`default_nettype wire

//--- test/move_and_interrupt_return_ops_tb.sv
// Directed testbench for the move, literal, no-op and interrupt return decoder
`default_nettype none
module move_and_interrupt_return_ops_tb;
    import op_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic              insn_valid = 1'b0;
    logic [13:0]       insn = 14'h0000;
    logic [7:0]        file_rdata = 8'h00;
    logic              call_push = 1'b0;
    logic [8:0]        call_addr = 9'h000;
    logic [8:0]        pc;
    logic [7:0]        w_reg;
    logic              zero_flag;
    logic [7:0]        irq_control_reg;
    logic              file_we;
    logic [6:0]        file_addr;
    logic [7:0]        file_wdata;
    logic              flush;
    logic              insn_ack;
    logic [8:0]        exp_pc = 9'h000;
    int                mismatches = 0;
    int                samples_checked = 0;

    always #4 clk = ~clk;

    move_ret_decoder u_move_ret_decoder (
        .clk(clk), .rstn(rstn), .insn_valid(insn_valid), .insn(insn),
        .file_rdata(file_rdata), .call_push(call_push),
        .call_addr(call_addr), .pc(pc), .w_reg(w_reg),
        .zero_flag(zero_flag), .irq_control_reg(irq_control_reg),
        .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata),
        .flush(flush), .insn_ack(insn_ack)
    );

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Called at a falling edge; one idle edge first, so the strobe is
    // never set twice in one step; returns with results settled
    task automatic exec(input logic [13:0] op, input logic [7:0] rd);
        @(negedge clk);
        insn = op;
        file_rdata = rd;
        insn_valid = 1'b1;
        @(negedge clk);
        insn_valid = 1'b0;
        exp_pc = exp_pc + 9'h001;
        chk(insn_ack, 1'b1, "ack");
        chk(pc, exp_pc, "pc");
    endtask

    task automatic t_literal();
        exec({PAT_LOAD_LIT, 2'b00, 8'h5a}, 8'h00);
        chk(w_reg, 8'h5a, "w lit");
        exec({PAT_LOAD_LIT, 2'b00, 8'h00}, 8'h00);
        chk(w_reg, 8'h00, "w lit0");
        chk(zero_flag, 1'b0, "z lit");
        $display("literal test done");
    endtask

    task automatic t_move();
        exec({PAT_LOAD_LIT, 2'b00, 8'h66}, 8'h00);
        exec({PAT_MOVE_FILE, 1'b0, 7'h7f}, 8'h00);
        chk(w_reg, 8'h00, "w move");
        chk(zero_flag, 1'b1, "z move w");
        chk(file_we, 1'b0, "we move w");
        exec({PAT_MOVE_FILE, 1'b1, 7'h00}, 8'h80);
        chk(file_we, 1'b1, "we move f");
        chk(file_addr, 7'h00, "addr move f");
        chk(file_wdata, 8'h80, "data move f");
        chk(w_reg, 8'h00, "w kept");
        chk(zero_flag, 1'b0, "z move f");
        $display("move test done");
    endtask

    task automatic t_store();
        exec({PAT_MOVE_FILE, 1'b1, 7'h11}, 8'h00);
        exec({PAT_LOAD_LIT, 2'b00, 8'ha7}, 8'h00);
        exec({PAT_STORE_ACC, 7'h55}, 8'h3c);
        chk(file_we, 1'b1, "we store");
        chk(file_addr, 7'h55, "addr store");
        chk(file_wdata, 8'ha7, "data store");
        chk(zero_flag, 1'b1, "z store");
        $display("store test done");
    endtask

    task automatic t_nop();
        exec(OPC_NOP, 8'hff);
        chk(w_reg, 8'ha7, "w nop");
        chk(zero_flag, 1'b1, "z nop");
        chk(file_we, 1'b0, "we nop");
        chk(irq_control_reg, 8'h00, "irq nop");
        $display("nop test done");
    endtask

    task automatic t_return();
        call_addr = 9'h1a5;
        call_push = 1'b1;
        @(negedge clk);
        call_push = 1'b0;
        insn = OPC_RETFIRQ;
        insn_valid = 1'b1;
        @(negedge clk);
        chk(flush, 1'b1, "flush");
        chk(insn_ack, 1'b1, "ack ret");
        chk(irq_control_reg, 8'h80, "irq enable");
        // Offered in the dead cycle, must be dropped
        insn = {PAT_LOAD_LIT, 2'b00, 8'hc3};
        @(negedge clk);
        insn_valid = 1'b0;
        chk(pc, 9'h1a5, "pc top");
        chk(insn_ack, 1'b0, "ack dead");
        chk(flush, 1'b0, "flush end");
        chk(w_reg, 8'ha7, "w dead");
        exp_pc = 9'h1a5;
        exec({PAT_LOAD_LIT, 2'b00, 8'h3e}, 8'h00);
        chk(w_reg, 8'h3e, "w after");
        $display("return test done");
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        chk(pc, 9'h000, "pc reset");
        t_literal();
        t_move();
        t_store();
        t_nop();
        t_return();
        report_and_stop();
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule
`default_nettype wire
